//--- rtl/flag_ops_regs.vh
`ifndef FLAG_OPS_REGS_VH
`define FLAG_OPS_REGS_VH

// Register byte addresses on the AXI4-Lite port.
`define ADDR_FLAGS       8'h00
`define ADDR_CONTROL0    8'h04
`define ADDR_PRIV        8'h08
`define ADDR_OPCODE      8'h0C
`define ADDR_MOVE_SRC    8'h10
`define ADDR_MOVE_DST    8'h14
`define ADDR_SRC_INDEX   8'h18
`define ADDR_DST_INDEX   8'h1C
`define ADDR_EVENT       8'h20
`define ADDR_STATUS      8'h24

// Field positions in the flags register.
`define FL_CARRY         0
`define FL_PARITY        2
`define FL_AUX           4
`define FL_ZERO          6
`define FL_SIGN          7
`define FL_INT_EN        9
`define FL_DIR           10
`define FL_OVERFLOW      11
`define FL_VM            17
`define FLAGS_MASK       32'h00020ED5
`define FLAGS_RESET      32'h00000000

// Field positions in control register zero.
`define CR0_PE           0
`define CR0_TS           3
`define CR0_RESET        32'h00000000

// Privilege register fields.
`define PRIV_CPL_LO      0
`define PRIV_IO_PRIVILEGE_LEVEL_LO     4

// Opcode register fields.
`define OPC_ESCAPE       8
`define OPC_SIZE32       9
`define OPC_BYTE_OPND    10

// Event register fields.
`define EV_TASK_SWITCH   0
`define EV_STRING_STEP   1
`define EV_STEP_LO       2

// Status register fields.
`define ST_BUSY          0
`define ST_GP_FAULT      1
`define ST_MOVE_TAKEN    2
`define ST_UNSUPPORTED   3

// Opcode bytes.
`define OP_CLEAR_DIR     8'hFC
`define OP_CLEAR_INT     8'hFA
`define OP_INVERT_CARRY  8'hF5
`define OP_CLEAR_TS      8'h06
`define OP_CMOV_HI       4'h4

// Error code delivered with a general protection fault.
`define GP_ERROR_CODE    16'h0000

// AXI responses.
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

//--- rtl/cmov_condition.v
`timescale 1ns/1ps
`include "flag_ops_regs.vh"

module cmov_condition (
	input  wire [3:0] cond_code,
	input  wire       carry_flag,
	input  wire       zero_flag,
	input  wire       sign_flag,
	input  wire       overflow_flag,
	input  wire       parity_flag,
	output reg        cond_true
);

	// Condition table for the conditional move opcodes 0F 40 to 0F 4F.
	always @* begin
		case (cond_code)
			4'h0: cond_true = overflow_flag;
			4'h1: cond_true = ~overflow_flag;
			4'h2: cond_true = carry_flag;
			4'h3: cond_true = ~carry_flag;
			4'h4: cond_true = zero_flag;
			4'h5: cond_true = ~zero_flag;
			4'h6: cond_true = carry_flag | zero_flag;
			4'h7: cond_true = ~carry_flag & ~zero_flag;
			4'h8: cond_true = sign_flag;
			4'h9: cond_true = ~sign_flag;
			4'hA: cond_true = parity_flag;
			4'hB: cond_true = ~parity_flag;
			4'hC: cond_true = sign_flag ^ overflow_flag;
			4'hD: cond_true = ~(sign_flag ^ overflow_flag);
			4'hE: cond_true = zero_flag | (sign_flag ^ overflow_flag);
			4'hF: cond_true = ~zero_flag & ~(sign_flag ^ overflow_flag);
			default: cond_true = 1'b0;
		endcase
	end

endmodule

//--- rtl/flag_ops_and_cond_move.v
`timescale 1ns/1ps
`include "flag_ops_regs.vh"

module flag_ops_and_cond_move (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        intr_req,
	input  wire        nmi_req,
	output reg         intr_take,
	output reg         nmi_take,
	output reg         general_protection_fault,
	output reg  [15:0] fault_error_code
);

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_EXEC = 2'b10;

	reg  [1:0]  state_q;
	reg  [31:0] flags_q;
	reg  [31:0] control0_q;
	reg  [31:0] priv_q;
	reg  [31:0] opcode_q;
	reg  [31:0] move_src_q;
	reg  [31:0] move_dst_q;
	reg  [31:0] src_index_q;
	reg  [31:0] dst_index_q;
	reg  [3:0]  status_q;
	reg  [7:0]  waddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         aw_full_q;
	reg         w_full_q;
	reg  [1:0]  intr_sync_q;
	reg  [1:0]  nmi_sync_q;
	wire        cond_true;
	wire        do_write;
	wire [31:0] wmerge_flags;
	wire [31:0] wmerge_control0;
	wire [31:0] wmerge_priv;
	wire [31:0] wmerge_src;
	wire [31:0] wmerge_dst;
	wire [31:0] wmerge_sidx;
	wire [31:0] wmerge_didx;
	wire [31:0] event_word;
	wire [31:0] step_size;
	wire [7:0]  op_byte;
	wire        op_escape;
	wire        is_cmov;
	wire        cli_ok;
	wire        clear_task_switched_op_ok;

	// Byte-lane merge of a write into the current register value.
	function [31:0] merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer      i;
		begin
			merge = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = new_val[i*8 +: 8];
				end
			end
		end
	endfunction

	// Interrupt-enable clear permission from mode and privilege levels.
	function cli_allowed;
		input       pe;
		input       vm;
		input [1:0] current_privilege_level;
		input [1:0] io_privilege_level;
		begin
			if (!pe) begin
				cli_allowed = 1'b1;
			end else if (!vm) begin
				cli_allowed = (current_privilege_level <= io_privilege_level);
			end else begin
				cli_allowed = (io_privilege_level == 2'd3);
			end
		end
	endfunction

	// Task-switched clear is privileged outside real mode.
	function clear_task_switched_op_allowed;
		input       pe;
		input [1:0] current_privilege_level;
		begin
			clear_task_switched_op_allowed = !pe || (current_privilege_level == 2'd0);
		end
	endfunction

	assign do_write        = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wmerge_flags    = merge(flags_q, wdata_q, wstrb_q) & `FLAGS_MASK;
	assign wmerge_control0 = merge(control0_q, wdata_q, wstrb_q);
	assign wmerge_priv     = merge(priv_q, wdata_q, wstrb_q) & 32'h00000033;
	assign wmerge_src      = merge(move_src_q, wdata_q, wstrb_q);
	assign wmerge_dst      = merge(move_dst_q, wdata_q, wstrb_q);
	assign wmerge_sidx     = merge(src_index_q, wdata_q, wstrb_q);
	assign wmerge_didx     = merge(dst_index_q, wdata_q, wstrb_q);
	assign event_word      = merge(32'h00000000, wdata_q, wstrb_q);
	assign op_byte         = opcode_q[7:0];
	assign op_escape       = opcode_q[`OPC_ESCAPE];
	assign is_cmov         = op_escape && (op_byte[7:4] == `OP_CMOV_HI);
	assign cli_ok          = cli_allowed(control0_q[`CR0_PE], flags_q[`FL_VM],
	                                     priv_q[`PRIV_CPL_LO +: 2], priv_q[`PRIV_IO_PRIVILEGE_LEVEL_LO +: 2]);
	assign clear_task_switched_op_ok         = clear_task_switched_op_allowed(control0_q[`CR0_PE], priv_q[`PRIV_CPL_LO +: 2]);

	// Element size of one string step: 1, 2 or 4 bytes.
	assign step_size = (event_word[`EV_STEP_LO +: 2] == 2'd2) ? 32'h00000004 :
	                   (event_word[`EV_STEP_LO +: 2] == 2'd1) ? 32'h00000002 : 32'h00000001;

	cmov_condition u_cond (
		.cond_code     (op_byte[3:0]),
		.carry_flag    (flags_q[`FL_CARRY]),
		.zero_flag     (flags_q[`FL_ZERO]),
		.sign_flag     (flags_q[`FL_SIGN]),
		.overflow_flag (flags_q[`FL_OVERFLOW]),
		.parity_flag   (flags_q[`FL_PARITY]),
		.cond_true     (cond_true)
	);

	// Two-flop synchronisers for the interrupt request pins.
	always @(posedge aclk) begin
		if (!aresetn) begin
			intr_sync_q <= 2'b00;
			nmi_sync_q  <= 2'b00;
		end else begin
			intr_sync_q <= {intr_sync_q[0], intr_req};
			nmi_sync_q  <= {nmi_sync_q[0], nmi_req};
		end
	end

	// Interrupt acceptance; the maskable path looks at the enable, the NMI path never does.
	always @(posedge aclk) begin
		if (!aresetn) begin
			intr_take <= 1'b0;
			nmi_take  <= 1'b0;
		end else begin
			intr_take <= intr_sync_q[1] && flags_q[`FL_INT_EN] && (state_q == ST_IDLE);
			nmi_take  <= nmi_sync_q[1];
		end
	end

	// Write address and data channels, accepted in either order.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			waddr_q       <= 8'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_q       <= s_axi_awaddr;
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (waddr_q)
					`ADDR_FLAGS, `ADDR_CONTROL0, `ADDR_PRIV, `ADDR_OPCODE, `ADDR_MOVE_SRC,
					`ADDR_MOVE_DST, `ADDR_SRC_INDEX, `ADDR_DST_INDEX, `ADDR_EVENT: begin
						s_axi_bresp <= `RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channel; one read in flight, data registered with the valid.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RESP_OKAY;
				case (s_axi_araddr)
					`ADDR_FLAGS:     s_axi_rdata <= flags_q;
					`ADDR_CONTROL0:  s_axi_rdata <= control0_q;
					`ADDR_PRIV:      s_axi_rdata <= priv_q;
					`ADDR_OPCODE:    s_axi_rdata <= opcode_q;
					`ADDR_MOVE_SRC:  s_axi_rdata <= move_src_q;
					`ADDR_MOVE_DST:  s_axi_rdata <= move_dst_q;
					`ADDR_SRC_INDEX: s_axi_rdata <= src_index_q;
					`ADDR_DST_INDEX: s_axi_rdata <= dst_index_q;
					`ADDR_EVENT:     s_axi_rdata <= 32'h00000000;
					`ADDR_STATUS:    s_axi_rdata <= {`GP_ERROR_CODE, 12'h000, status_q};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Register file and instruction execution. An opcode write is executed on the next edge,
	// and every flag it touches is updated on that one edge, so no half-updated state is seen.
	// Bus writes cannot land on the execute edge because the write response is still pending.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q                  <= ST_IDLE;
			flags_q                  <= `FLAGS_RESET;
			control0_q               <= `CR0_RESET;
			priv_q                   <= 32'h00000000;
			opcode_q                 <= 32'h00000000;
			move_src_q               <= 32'h00000000;
			move_dst_q               <= 32'h00000000;
			src_index_q              <= 32'h00000000;
			dst_index_q              <= 32'h00000000;
			status_q                 <= 4'h0;
			general_protection_fault <= 1'b0;
			fault_error_code         <= `GP_ERROR_CODE;
		end else begin
			general_protection_fault <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (do_write) begin
						case (waddr_q)
							`ADDR_FLAGS:     flags_q     <= wmerge_flags;
							`ADDR_CONTROL0:  control0_q  <= wmerge_control0;
							`ADDR_PRIV:      priv_q      <= wmerge_priv;
							`ADDR_MOVE_SRC:  move_src_q  <= wmerge_src;
							`ADDR_MOVE_DST:  move_dst_q  <= wmerge_dst;
							`ADDR_SRC_INDEX: src_index_q <= wmerge_sidx;
							`ADDR_DST_INDEX: dst_index_q <= wmerge_didx;
							`ADDR_OPCODE: begin
								opcode_q <= merge(opcode_q, wdata_q, wstrb_q) & 32'h000007FF;
								status_q <= 4'h1;
								state_q  <= ST_EXEC;
							end
							`ADDR_EVENT: begin
								if (event_word[`EV_TASK_SWITCH]) begin
									control0_q[`CR0_TS] <= 1'b1;
								end
								if (event_word[`EV_STRING_STEP]) begin
									if (!flags_q[`FL_DIR]) begin
										src_index_q <= src_index_q + step_size;
										dst_index_q <= dst_index_q + step_size;
									end else begin
										src_index_q <= src_index_q - step_size;
										dst_index_q <= dst_index_q - step_size;
									end
								end
							end
							default: begin
								state_q <= ST_IDLE;
							end
						endcase
					end
				end
				ST_EXEC: begin
					state_q            <= ST_IDLE;
					status_q[`ST_BUSY] <= 1'b0;
					if (!op_escape && op_byte == `OP_CLEAR_DIR) begin
						flags_q[`FL_DIR] <= 1'b0;
					end else if (!op_escape && op_byte == `OP_INVERT_CARRY) begin
						flags_q[`FL_CARRY] <= ~flags_q[`FL_CARRY];
					end else if (!op_escape && op_byte == `OP_CLEAR_INT) begin
						if (cli_ok) begin
							flags_q[`FL_INT_EN] <= 1'b0;
						end else begin
							general_protection_fault <= 1'b1;
							fault_error_code         <= `GP_ERROR_CODE;
							status_q[`ST_GP_FAULT]   <= 1'b1;
						end
					end else if (op_escape && op_byte == `OP_CLEAR_TS) begin
						if (clear_task_switched_op_ok) begin
							control0_q[`CR0_TS] <= 1'b0;
						end else begin
							general_protection_fault <= 1'b1;
							fault_error_code         <= `GP_ERROR_CODE;
							status_q[`ST_GP_FAULT]   <= 1'b1;
						end
					end else if (is_cmov) begin
						if (opcode_q[`OPC_BYTE_OPND]) begin
							status_q[`ST_UNSUPPORTED] <= 1'b1;
						end else if (cond_true) begin
							status_q[`ST_MOVE_TAKEN] <= 1'b1;
							if (opcode_q[`OPC_SIZE32]) begin
								move_dst_q <= move_src_q;
							end else begin
								move_dst_q[15:0] <= move_src_q[15:0];
							end
						end
						// A false condition leaves the destination alone and returns to idle.
					end else begin
						status_q[`ST_UNSUPPORTED] <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

//--- verif/irq_source.sv
`timescale 1ns/1ps
module irq_source (
	input  wire  intr_level,
	input  wire  nmi_level,
	output logic intr_req,
	output logic nmi_req
);
	// Both pins start inactive so the synchronisers never see an unknown.
	initial begin
		intr_req = 1'b0;
		nmi_req = 1'b0;
	end

	// A real source is unrelated to the core clock, so pins move between edges.
	always @(intr_level) intr_req <= #7 intr_level;
	always @(nmi_level) nmi_req <= #7 nmi_level;
endmodule

//--- verif/flag_ops_props.sv
`timescale 1ns/1ps
module flag_ops_props (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        intr_req,
	input wire        nmi_req,
	input wire        intr_take,
	input wire        nmi_take,
	input wire        general_protection_fault,
	input wire [15:0] fault_error_code
);
	// Everything here lives in the core clock domain.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Fault signalling is a single pulse carrying error code zero, right after a write.
	fault_pulse_a: assert property (general_protection_fault |=> !general_protection_fault)
		else $error("fault pulse longer than one cycle");
	fault_code_a: assert property (general_protection_fault |-> fault_error_code == 16'h0000)
		else $error("fault error code not zero");
	fault_boundary_a: assert property (general_protection_fault |-> $past(s_axi_bvalid))
		else $error("fault not at the instruction boundary");

	// Four samples cover the reset edge plus the three-edge pin latency.
	nmi_pass_a: assert property (nmi_req [*4] |=> nmi_take)
		else $error("non-maskable request not taken");
	nmi_drop_a: assert property ((!nmi_req) [*4] |=> !nmi_take)
		else $error("non-maskable take without request");
	intr_drop_a: assert property ((!intr_req) [*4] |=> !intr_take)
		else $error("maskable take without request");

	// Register port handshakes.
	// The write readies drop on the take edge, the write response follows one edge later; read data comes on the take edge.
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
		else $error("write response missing");
	wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write not released");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing");
	rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not released");
endmodule

bind flag_ops_and_cond_move flag_ops_props flag_ops_props_i (.*);

//--- verif/flag_ops_and_cond_move_tb_top.sv
`timescale 1ns/1ps
module flag_ops_and_cond_move_tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, got;
	logic [1:0]  resp;
	logic        intr_level, nmi_level;
	wire         awready, wready, bvalid, arready, rvalid, intr_req, nmi_req, intr_take, nmi_take, gp;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [15:0] ecode;
	int          fail_count, n_checks, seed;
	logic [10:0] ops [16] = '{11'h0FC, 11'h0FA, 11'h0F5, 11'h106, 11'h142, 11'h143, 11'h144, 11'h145,
		11'h146, 11'h147, 11'h14C, 11'h14D, 11'h14E, 11'h14F, 11'h547, 11'h090};

	flag_ops_and_cond_move flag_ops_and_cond_move_i (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .intr_req(intr_req),
		.nmi_req(nmi_req), .intr_take(intr_take), .nmi_take(nmi_take),
		.general_protection_fault(gp), .fault_error_code(ecode)
	);

	irq_source irq_source_i (
		.intr_level(intr_level),
		.nmi_level(nmi_level),
		.intr_req(intr_req),
		.nmi_req(nmi_req)
	);

	// Free-running core clock.
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic chk(input [31:0] g, input [31:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic summarize;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Address and data are offered together and each is dropped once taken.
	task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
		bit aw, w;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1;
		w = 1;
		do begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 0;
				wvalid <= 1'b0;
			end
		end while (!bvalid);
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	function automatic bit cond(input [7:0] op, input [31:0] f);
		case (op)
			8'h42: return f[0];
			8'h43: return !f[0];
			8'h44: return f[6];
			8'h45: return !f[6];
			8'h46: return f[0] | f[6];
			8'h47: return !f[0] & !f[6];
			8'h4C: return f[7] != f[11];
			8'h4D: return f[7] == f[11];
			8'h4E: return f[6] | (f[7] != f[11]);
			default: return !f[6] & (f[7] == f[11]);
		endcase
	endfunction

	// Load random machine state, execute one opcode and compare against the expected state.
	task automatic step_op(input [10:0] op);
		logic [31:0] fl, c0, src, dst, efl, ec0, edst;
		logic        pe, ts, gpe, mv, un;
		logic [1:0]  current_privilege_level, io_privilege_level;
		fl = $random(seed) & 32'h00020ED5;
		pe = $random(seed);
		ts = $random(seed);
		current_privilege_level = $random(seed);
		io_privilege_level = $random(seed);
		src = $random(seed);
		dst = $random(seed);
		if (!pe) fl[17] = 1'b0;
		if (op[8] && op[7:0] != 8'h06) op[9] = $random(seed);
		c0 = {28'h0, ts, 2'b00, pe};
		wr(8'h00, fl, 2'b00);
		wr(8'h04, c0, 2'b00);
		wr(8'h08, {26'h0, io_privilege_level, 2'b00, current_privilege_level}, 2'b00);
		wr(8'h10, src, 2'b00);
		wr(8'h14, dst, 2'b00);
		wr(8'h0C, {21'h0, op}, 2'b00);
		efl = fl;
		ec0 = c0;
		edst = dst;
		gpe = 0;
		mv = 0;
		un = 0;
		if (op == 11'h0FC) efl[10] = 1'b0;
		else if (op == 11'h0F5) efl[0] = ~fl[0];
		else if (op == 11'h0FA) begin
			if (!pe || (fl[17] ? io_privilege_level == 2'd3 : current_privilege_level <= io_privilege_level)) efl[9] = 1'b0;
			else gpe = 1;
		end else if (op == 11'h106) begin
			if (!pe || current_privilege_level == 2'd0) ec0[3] = 1'b0;
			else gpe = 1;
		end else if (op[8] && op[7:4] == 4'h4 && !op[10]) begin
			mv = cond(op[7:0], fl);
			if (mv) edst = op[9] ? src : {dst[31:16], src[15:0]};
		end else un = 1;
		// The fault pulse stands only in the cycle after the execute edge.
		@(posedge aclk);
		chk(gp, gpe);
		chk(ecode, 16'h0000);
		rd(8'h00, got, resp);
		chk(got, efl);
		rd(8'h04, got, resp);
		chk(got, ec0);
		rd(8'h14, got, resp);
		chk(got, edst);
		rd(8'h24, got, resp);
		chk(got[3:1], {un, mv, gpe});
	endtask

	// Main sequence.
	initial begin
		logic [31:0] sx, dx;
		{awvalid, wvalid, bready, arvalid, rready, intr_level, nmi_level} = '0;
		{awaddr, araddr, wdata} = '0;
		fail_count = 0;
		n_checks = 0;
		seed = 32'hef2d;
		aresetn = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, got, resp);
		chk(got, 32'h0);
		rd(8'h04, got, resp);
		chk(got, 32'h0);
		wr(8'h40, 32'h1234_5678, 2'b10);
		rd(8'h40, got, resp);
		chk(got, 32'h0);
		chk(resp, 2'b10);
		for (int i = 0; i < 60; i++) step_op(ops[i < 16 ? i : $unsigned($random(seed)) % 16]);
		// Index stepping for both directions and every step size.
		for (int i = 0; i < 6; i++) begin
			sx = $random(seed);
			dx = $random(seed);
			wr(8'h00, (i > 2) ? 32'h400 : 32'h0, 2'b00);
			wr(8'h18, sx, 2'b00);
			wr(8'h1C, dx, 2'b00);
			wr(8'h20, {28'h0, 2'(i % 3), 2'b10}, 2'b00);
			rd(8'h18, got, resp);
			chk(got, (i > 2) ? sx - (1 << (i % 3)) : sx + (1 << (i % 3)));
			rd(8'h1C, got, resp);
			chk(got, (i > 2) ? dx - (1 << (i % 3)) : dx + (1 << (i % 3)));
		end
		wr(8'h04, 32'h0, 2'b00);
		wr(8'h20, 32'h1, 2'b00);
		rd(8'h04, got, resp);
		chk(got, 32'h8);
		// Mask the maskable request with the clear while the other keeps being taken.
		wr(8'h00, 32'h200, 2'b00);
		intr_level <= 1'b1;
		nmi_level <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(intr_take, 1'b1);
		chk(nmi_take, 1'b1);
		wr(8'h0C, 32'h0FA, 2'b00);
		repeat (3) @(posedge aclk);
		chk(intr_take, 1'b0);
		chk(nmi_take, 1'b1);
		intr_level <= 1'b0;
		nmi_level <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(nmi_take, 1'b0);
		summarize();
	end

	// A hang ends the run as a mismatch.
	initial begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		summarize();
	end
endmodule
